// >>> halt_power_map.vh
// constants for the halt mode power controller
`ifndef HALT_POWER_MAP_VH
`define HALT_POWER_MAP_VH
`define CYC_DIV          4'h9
`define CYC_DIV_LAST     4'h8
`define START_DELAY      9'h100
`define HALT_DISABLE_BIT 0
`define OSC_RC           2'h0
`define OSC_XTAL         2'h1
`define OSC_EXT          2'h2
`define OSC_XTAL_BIAS    2'h3
`endif

// >>> halt_mode_power_control.v
// halt mode power control: entry, wake sources, start-up delay, clock gating
`timescale 1ns/100ps
`include "halt_power_map.vh"

module halt_mode_power_control (
	input  wire       mclk,
	input  wire       rst_n,
	input  wire       halt_flag_write,
	input  wire       halt_flag_value,
	input  wire       idle_flag_write,
	input  wire       idle_flag_value,
	input  wire [7:0] option_config_register,
	input  wire       rc_wake_delay_write,
	input  wire       rc_wake_delay_value,
	input  wire [1:0] osc_select,
	input  wire [7:0] wake_enable,
	input  wire [7:0] wake_pending,
	input  wire       clock_output_pin,
	input  wire       osc_schmitt,
	input  wire       clock_monitor_enable,
	input  wire       clock_monitor_error,
	input  wire       idle_wake,
	output reg        upper_port_bit_seven,
	output reg        upper_port_bit_six,
	output reg        rc_wake_delay_select,
	output reg        halted,
	output reg        osc_enable,
	output reg        chip_clock_enable,
	output reg        timers_enable,
	output reg        fault_timer_enable,
	output reg        fault_output_pin,
	output reg        resume_at_halt_point,
	output reg        clock_input_force_high,
	output reg        clock_input_oe,
	output reg        cycle_tick,
	output reg  [8:0] idle_timer
);

	localparam [3:0] S_RUN   = 4'h1;
	localparam [3:0] S_HALT  = 4'h2;
	localparam [3:0] S_START = 4'h4;
	localparam [3:0] S_IDLE  = 4'h8;

	// every pin-side input passes two flops before logic reads it
	reg [7:0] wen_s0_q, wen_s1_q, wpn_s0_q, wpn_s1_q;
	reg       cko_s0_q, cko_s1_q, cko_prev_q;
	reg       sch_s0_q, sch_s1_q, sch_prev_q;
	reg       cme_s0_q, cme_s1_q, cmr_s0_q, cmr_s1_q;
	reg       iw_s0_q, iw_s1_q;
	reg [3:0] state_q, state_d;
	reg [3:0] div_q;

	genvar gi;
	generate
		for (gi = 0; gi < 8; gi = gi + 1) begin : g_wake_sync
			always @(posedge mclk or negedge rst_n) begin
				if (!rst_n) begin
					wen_s0_q[gi] <= 1'b0;
					wen_s1_q[gi] <= 1'b0;
					wpn_s0_q[gi] <= 1'b0;
					wpn_s1_q[gi] <= 1'b0;
				end else begin
					wen_s0_q[gi] <= wake_enable[gi];
					wen_s1_q[gi] <= wen_s0_q[gi];
					wpn_s0_q[gi] <= wake_pending[gi];
					wpn_s1_q[gi] <= wpn_s0_q[gi];
				end
			end
		end
	endgenerate

	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			cko_s0_q   <= 1'b0;
			cko_s1_q   <= 1'b0;
			cko_prev_q <= 1'b0;
		end else begin
			cko_s0_q   <= clock_output_pin;
			cko_s1_q   <= cko_s0_q;
			cko_prev_q <= cko_s1_q;
		end
	end

	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			sch_s0_q   <= 1'b0;
			sch_s1_q   <= 1'b0;
			sch_prev_q <= 1'b0;
		end else begin
			sch_s0_q   <= osc_schmitt;
			sch_s1_q   <= sch_s0_q;
			sch_prev_q <= sch_s1_q;
		end
	end

	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			cme_s0_q <= 1'b0;
			cme_s1_q <= 1'b0;
		end else begin
			cme_s0_q <= clock_monitor_enable;
			cme_s1_q <= cme_s0_q;
		end
	end

	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			cmr_s0_q <= 1'b0;
			cmr_s1_q <= 1'b0;
		end else begin
			cmr_s0_q <= clock_monitor_error;
			cmr_s1_q <= cmr_s0_q;
		end
	end

	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			iw_s0_q <= 1'b0;
			iw_s1_q <= 1'b0;
		end else begin
			iw_s0_q <= idle_wake;
			iw_s1_q <= iw_s0_q;
		end
	end

	wire is_rc     = (osc_select == `OSC_RC);
	wire wake_port = |(wen_s1_q & wpn_s1_q);
	// a crystal drives the clock output pin, so its edges are not a wake source
	wire wake_cko  = is_rc & cko_s1_q & ~cko_prev_q;
	wire wake_any  = wake_port | wake_cko;
	wire halt_off  = option_config_register[`HALT_DISABLE_BIT];
	wire halt_req  = halt_flag_write & halt_flag_value & ~halt_off & ~wake_port;
	wire idle_req  = idle_flag_write & idle_flag_value;
	wire need_dly  = ~is_rc | rc_wake_delay_select;
	// one count per rising oscillator edge that cleared the schmitt trigger
	wire osc_edge  = sch_s1_q & ~sch_prev_q;
	wire tick_d    = osc_edge & (div_q == `CYC_DIV_LAST);

	always @* begin
		state_d = state_q;
		case (state_q)
			S_RUN: begin
				if (halt_req)
					state_d = S_HALT;
				else if (idle_req)
					state_d = S_IDLE;
			end
			S_HALT: begin
				if (wake_any)
					state_d = need_dly ? S_START : S_RUN;
			end
			S_START: begin
				if (cycle_tick && idle_timer == 9'h001)
					state_d = S_RUN;
			end
			S_IDLE: begin
				if (wake_port || iw_s1_q)
					state_d = S_RUN;
			end
			default: state_d = S_RUN;
		endcase
	end

	// divide-by-nine prescaler on qualified oscillator edges
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			div_q <= 4'h0;
		end else begin
			if (osc_edge)
				div_q <= (div_q == `CYC_DIV_LAST) ? 4'h0 : div_q + 4'h1;
		end
	end

	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			cycle_tick <= 1'b0;
		end else begin
			cycle_tick <= tick_d;
		end
	end

	// reset itself is the third wake path: asynchronous, back to run
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= S_RUN;
		end else begin
			state_q <= state_d;
		end
	end

	// flag reads zero after any wake; disable option pins it at zero
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			upper_port_bit_seven <= 1'b0;
			upper_port_bit_six   <= 1'b0;
		end else begin
			upper_port_bit_seven <= (state_d == S_HALT);
			upper_port_bit_six   <= (state_d == S_IDLE);
		end
	end

	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			rc_wake_delay_select <= 1'b0;
		end else begin
			if (rc_wake_delay_write)
				rc_wake_delay_select <= rc_wake_delay_value;
		end
	end

	// the idle timer counts down in start-up and up in idle; it holds in halt
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			idle_timer <= 9'h000;
		end else begin
			if (state_q == S_HALT && state_d == S_START)
				idle_timer <= `START_DELAY;
			else if (state_q == S_START && cycle_tick)
				idle_timer <= idle_timer - 9'h001;
			else if (state_q == S_IDLE && cycle_tick)
				idle_timer <= idle_timer + 9'h001;
		end
	end

	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			halted <= 1'b0;
		end else begin
			halted <= (state_d == S_HALT);
		end
	end

	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			osc_enable <= 1'b1;
		end else begin
			osc_enable <= (state_d != S_HALT);
		end
	end

	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			chip_clock_enable <= 1'b1;
		end else begin
			chip_clock_enable <= (state_d == S_RUN);
		end
	end

	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			timers_enable <= 1'b1;
		end else begin
			timers_enable <= (state_d == S_RUN);
		end
	end

	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			fault_timer_enable <= 1'b1;
		end else begin
			fault_timer_enable <= (state_d == S_RUN) || (state_d == S_IDLE);
		end
	end

	// monitor stays live in halt so a runaway halt is caught
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			fault_output_pin <= 1'b1;
		end else begin
			fault_output_pin <= ~(cme_s1_q & cmr_s1_q);
		end
	end

	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			resume_at_halt_point <= 1'b0;
		end else begin
			if (state_q == S_HALT && state_d != S_HALT)
				resume_at_halt_point <= 1'b1;
			else if (state_d == S_RUN)
				resume_at_halt_point <= 1'b0;
		end
	end

	// pad is never driven; in halt, rc forces the internal node high
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			clock_input_force_high <= 1'b0;
		end else begin
			clock_input_force_high <= is_rc && (state_d == S_HALT);
		end
	end

	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			clock_input_oe <= 1'b0;
		end else begin
			clock_input_oe <= 1'b0;
		end
	end

endmodule

// >>> halt_far_side.sv
// far side model: oscillator after the schmitt trigger, clock output pin
`timescale 1ns/100ps
module halt_far_side (
	input  wire mclk,
	input  wire osc_enable,
	input  wire pin_req,
	output reg  osc_schmitt,
	output reg  clock_output_pin
);
	initial {osc_schmitt, clock_output_pin} = 2'h0;
	// a stopped oscillator never passes the trigger, so it reads low
	always @(posedge mclk) begin
		osc_schmitt <= osc_enable ? ~osc_schmitt : 1'b0;
		clock_output_pin <= pin_req;
	end
endmodule

// >>> halt_power_checker.sv
// port assertions for the halt mode power control block
`timescale 1ns/100ps
module halt_power_checker (
	input wire mclk,
	input wire rst_n,
	input wire [7:0] option_config_register,
	input wire [1:0] osc_select,
	input wire [7:0] wake_enable,
	input wire [7:0] wake_pending,
	input wire clock_monitor_error,
	input wire upper_port_bit_seven,
	input wire halted,
	input wire chip_clock_enable,
	input wire timers_enable,
	input wire fault_timer_enable,
	input wire fault_output_pin,
	input wire clock_input_force_high,
	input wire cycle_tick
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	a_halt_stops: assert property ($rose(halted) |-> !chip_clock_enable && !timers_enable && upper_port_bit_seven)
		else $error("halt entry");
	a_fault_held: assert property (halted |-> !fault_timer_enable)
		else $error("fault timer");
	a_monitor_runs: assert property ((halted && clock_monitor_error) [*4] |-> !fault_output_pin)
		else $error("monitor");
	a_halt_disabled: assert property (option_config_register[0] [*2] |-> !$rose(upper_port_bit_seven))
		else $error("disabled halt");
	a_pending_blocks: assert property ((|(wake_enable & wake_pending)) [*4] |-> !$rose(upper_port_bit_seven))
		else $error("pending halt");
	a_rc_pin_high: assert property (halted |-> clock_input_force_high == (osc_select == 2'h0))
		else $error("clock pin");
	a_tick_gap: assert property (cycle_tick |=> !cycle_tick [*8])
		else $error("tick");
	a_wake_clears: assert property ($fell(halted) |-> !upper_port_bit_seven)
		else $error("flag");
endmodule

// >>> halt_mode_power_control_bench.sv
// self-checking bench for the halt mode power control block
`timescale 1ns/100ps
module halt_mode_power_control_bench;
	reg        mclk, rst_n, halt_flag_write, halt_flag_value, idle_flag_write, idle_flag_value, pin_req, idle_wake;
	reg        rc_wake_delay_write, rc_wake_delay_value, clock_monitor_enable, clock_monitor_error;
	reg  [7:0] option_config_register, wake_enable, wake_pending;
	reg  [1:0] osc_select;
	wire       upper_port_bit_seven, upper_port_bit_six, rc_wake_delay_select, halted, osc_enable, osc_schmitt;
	wire       chip_clock_enable, timers_enable, fault_timer_enable, fault_output_pin, resume_at_halt_point;
	wire       clock_input_force_high, clock_input_oe, cycle_tick, clock_output_pin;
	wire [8:0] idle_timer;
	reg [31:0] seed;
	integer    err_total, checks, t, n, seen;
	halt_far_side i_halt_far_side (.*);
	halt_mode_power_control i_halt_mode_power_control (.*);
	function automatic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		rnd = seed;
	endfunction
	task chk(input [8:0] s, input [8:0] e);
		checks = checks + 1;
		if (s !== e) begin
			err_total = err_total + 1;
			$display("Error %0t seen %h exp %h", $time, s, e);
		end
	endtask
	task end_of_test;
		$display("checks %0d err_total %0d", checks, err_total);
		if (err_total == 0 && checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task cyc(input integer k);
		repeat (k) @(posedge mclk);
	endtask
	task halt_req;
		halt_flag_write <= 1'b1;
		cyc(1);
		halt_flag_write <= 1'b0;
		cyc(3);
	endtask
	task halt_wake(input [1:0] os, input pin, input integer exp);
		osc_select <= os;
		cyc(4);
		halt_req;
		chk(upper_port_bit_seven, 1);
		chk(chip_clock_enable, 0);
		chk(timers_enable, 0);
		chk(halted, 1);
		chk(osc_enable, 0);
		chk(fault_timer_enable, 0);
		chk(clock_input_oe, 0);
		chk(clock_input_force_high, os == 2'h0);
		clock_monitor_error <= 1'b1;
		cyc(6);
		chk(fault_output_pin, 0);
		clock_monitor_error <= 1'b0;
		if (pin) pin_req <= 1'b1;
		else wake_pending <= wake_enable;
		{t, n, seen} = 0;
		while (chip_clock_enable !== 1'b1 && n < 9000) begin
			cyc(1);
			n = n + 1;
			t = t + (cycle_tick === 1'b1);
			seen = seen | (resume_at_halt_point === 1'b1);
		end
		chk(t, exp);
		chk(seen, 1);
		chk(upper_port_bit_seven, 0);
		pin_req <= 1'b0;
		wake_pending <= 8'h00;
	endtask
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	initial begin
		#300000;
		err_total = err_total + 1;
		end_of_test;
	end
	initial begin
		{rst_n, halt_flag_write, halt_flag_value, idle_flag_write, idle_flag_value, pin_req, idle_wake} = 7'h00;
		{rc_wake_delay_write, rc_wake_delay_value, clock_monitor_error, osc_select} = 5'h00;
		// monitor left enabled on purpose, so the fault pin must fall in halt
		{clock_monitor_enable, option_config_register, wake_enable, wake_pending} = 25'h1010000;
		{seed, err_total, checks} = {32'h0000A6CE, 64'h0};
		cyc(16);
		rst_n <= 1'b1;
		halt_flag_value <= 1'b1;
		cyc(2);
		chk(rc_wake_delay_select, 0);
		halt_req;
		chk(upper_port_bit_seven, 0);
		option_config_register <= 8'h00;
		wake_enable <= 8'h01 << (rnd() % 8);
		wake_pending <= 8'hFF;
		cyc(4);
		halt_req;
		chk(upper_port_bit_seven, 0);
		wake_pending <= 8'h00;
		halt_wake(2'h0, 1, 0);
		halt_wake(2'h1, 0, 256);
		{rc_wake_delay_write, rc_wake_delay_value} <= 2'h3;
		cyc(1);
		rc_wake_delay_write <= 1'b0;
		halt_wake(2'h0, 1, 256);
		chk(rc_wake_delay_select, 1);
		idle_flag_value <= 1'b1;
		idle_flag_write <= 1'b1;
		cyc(1);
		idle_flag_write <= 1'b0;
		cyc(3);
		chk(upper_port_bit_six, 1);
		chk(chip_clock_enable, 0);
		chk(fault_timer_enable, 1);
		idle_wake <= 1'b1;
		cyc(6);
		chk(upper_port_bit_six, 0);
		chk(chip_clock_enable, 1);
		idle_wake <= 1'b0;
		cyc(2);
		end_of_test;
	end
endmodule
bind halt_mode_power_control halt_power_checker i_halt_power_checker (.*);
